// ==== sgram_command_timing_guard.v ====
// Purpose: host command gate that spaces commands to a graphics DRAM
// Assumes: one user command per command clock, taken at the launch tick
// Notes: command clock is mclk divided by 2*CK_HALF and driven out
`timescale 1ns/100ps
`default_nettype none
`include "sgram_timing_map.vh"
module sgram_command_timing_guard #(
   parameter GRADE = 0,
   parameter CK_HALF = 8,
   parameter WL = 4,
   parameter BL = 8,
   parameter XSR_CYCLES = `XSR_CK,
   parameter RAS_MAX_CYCLES = `RAS_MAX_CK
) (
   input wire mclk,
   input wire srst,
   input wire cmd_valid,
   input wire [3:0] cmd_code,
   input wire [2:0] cmd_bank,
   input wire [12:0] cmd_addr,
   output wire cmd_ready,
   output wire refresh_due,
   output wire row_overdue,
   output wire self_refresh,
   output wire ck_out,
   output wire cke_out,
   output wire cs_n_out,
   output wire ras_n_out,
   output wire cas_n_out,
   output wire we_n_out,
   output wire [2:0] ba_out,
   output wire [12:0] addr_out,
   output wire write_strobe_out,
   output wire write_strobe_oe_n
);
   function integer gsel;
      input integer g;
      input integer v0;
      input integer v1;
      input integer v2;
      input integer v3;
      begin
         gsel = (g == 0) ? v0 : (g == 1) ? v1 : (g == 2) ? v2 : v3;
      end
   endfunction

   function ge;
      input [`AGE_W-1:0] a;
      input integer n;
      begin
         ge = ({15'h0000, a} >= n);
      end
   endfunction

   // write data ends this many clocks after the write command
   localparam integer WDAT = WL + BL / 2;
   localparam integer T_RFC = gsel(GRADE, `RFC_G0, `RFC_G0, `RFC_G2, `RFC_G3);
   localparam integer T_RCDR = gsel(GRADE, `RCDR_G0, `RCDR_G0, `RCDR_G2, `RCDR_G3);
   localparam integer T_RCDW = gsel(GRADE, `RCDW_G0, `RCDW_G0, `RCDW_G2, `RCDW_G3);
   localparam integer T_RRD = gsel(GRADE, `RRD_G0, `RRD_G0, `RRD_G2, `RRD_G3);
   localparam integer T_WR = gsel(GRADE, `WR_G0, `WR_G0, `WR_G2, `WR_G3) + WDAT;
   localparam integer T_CDLR = gsel(GRADE, `CDLR_G0, `CDLR_G0, `CDLR_G2, `CDLR_G2) + WDAT;
   localparam integer T_MRD = gsel(GRADE, `MRD_G0, `MRD_G0, `MRD_G2, `MRD_G3);
   localparam integer T_DAL = gsel(GRADE, `DAL_G0, `DAL_G0, `DAL_G2, `DAL_G3) + WDAT;
   localparam integer T_XSNR = gsel(GRADE, `XSNR_G0, `XSNR_G0, `XSNR_G0, `XSNR_G3);
   localparam integer T_FAW = gsel(GRADE, `FAW_G0, `FAW_G0, `FAW_G2, `FAW_G3);
   localparam integer T_RAS = gsel(GRADE, `RAS_G0, `RAS_G0, `RAS_G2, `RAS_G3);
   localparam integer T_RC = gsel(GRADE, `RC_G0, `RC_G0, `RC_G2, `RC_G3);
   localparam integer T_RP = gsel(GRADE, `RP_G0, `RP_G0, `RP_G2, `RP_G3);
   localparam integer T_REFI = `REFRESH_INTERVAL_NS / (2 * CK_HALF * `MCLK_NS);
   // strobe sequence positions, in half clocks after the write launch
   localparam [7:0] H_PRE_HI = 2 * WL - 4;
   localparam [7:0] H_PRE_LO = 2 * WL - 2;
   localparam [7:0] H_BURST = 2 * WL;
   localparam [7:0] H_POST = 2 * WL + BL;
   localparam [7:0] H_END = 2 * WL + BL + 2;
   // age counter slots
   localparam NAGE = 34;
   localparam A_PRE = 8;
   localparam A_WR = 16;
   localparam A_REF = 24;
   localparam A_MRS = 25;
   localparam A_SRX = 26;
   localparam A_ACT = 27;
   localparam A_WRG = 28;
   localparam A_CKE = 29;
   localparam A_FAW = 30;

   reg [7:0] div_ff;
   reg ck_ff;
   reg cke_ff;
   reg sr_ff;
   reg [3:0] pin_ff;
   reg [2:0] ba_ff;
   reg [12:0] addr_ff;
   reg [7:0] open_ff;
   reg [7:0] apre_ff;
   reg [1:0] faw_ptr_ff;
   reg wbusy_ff;
   reg [7:0] hs_ff;
   reg ws_ff;
   reg ws_oe_n_ff;
   reg legal;
   reg [NAGE-1:0] ev;
   reg [3:0] nxt_pin;
   reg nxt_ws;
   reg nxt_ws_oe_n;
   wire [`AGE_W-1:0] age [0:NAGE-1];
   wire half;
   wire tick;
   wire take;
   wire [7:0] bsel;
   wire all_closed;
   genvar gi;

   // command clock divider; commands launch on its falling edge so
   // they are stable half a clock before the device samples them
   assign half = (div_ff == CK_HALF - 1);
   assign tick = half & ck_ff;
   always @(posedge mclk) begin
      if (srst) begin
         div_ff <= 8'h00;
         ck_ff <= 1'b0;
      end else begin
         div_ff <= half ? 8'h00 : div_ff + 8'h01;
         ck_ff <= half ? ~ck_ff : ck_ff;
      end
   end

   generate
      for (gi = 0; gi < NAGE; gi = gi + 1) begin : g_age
         event_age_counter #(.W(`AGE_W)) u_age (
            .mclk(mclk),
            .srst(srst),
            .tick(tick),
            .clear(ev[gi]),
            .age(age[gi])
         );
      end
   endgenerate

   assign bsel = 8'h01 << cmd_bank;
   assign all_closed = (open_ff == 8'h00);
   // refresh owed once the interval since the last one has run out
   assign refresh_due = ge(age[A_REF], T_REFI);
   assign row_overdue = |(open_ff & {ge(age[7], RAS_MAX_CYCLES), ge(age[6], RAS_MAX_CYCLES),
      ge(age[5], RAS_MAX_CYCLES), ge(age[4], RAS_MAX_CYCLES), ge(age[3], RAS_MAX_CYCLES),
      ge(age[2], RAS_MAX_CYCLES), ge(age[1], RAS_MAX_CYCLES), ge(age[0], RAS_MAX_CYCLES)});

   // legality of the offered command against every spacing limit
   always @* begin
      legal = ge(age[A_REF], T_RFC) && ge(age[A_MRS], T_MRD);
      if (cmd_code != `CMD_RD && cmd_code != `CMD_SRX) begin
         legal = legal && ge(age[A_SRX], T_XSNR);
      end
      if (refresh_due && cmd_code != `CMD_PRE && cmd_code != `CMD_REF) begin
         legal = 1'b0;
      end
      if (sr_ff && cmd_code != `CMD_SRX) begin
         legal = 1'b0;
      end
      case (cmd_code)
         `CMD_ACT: begin
            legal = legal && !open_ff[cmd_bank] && ge(age[A_PRE + cmd_bank], T_RP)
               && ge(age[cmd_bank], T_RC)
               && ge(age[A_ACT], T_RRD)
               && ge(age[A_FAW + faw_ptr_ff], T_FAW)
               && (!apre_ff[cmd_bank] || ge(age[A_WR + cmd_bank], T_DAL));
         end
         `CMD_RD: begin
            legal = legal && open_ff[cmd_bank] && ge(age[cmd_bank], T_RCDR)
               && ge(age[A_WRG], T_CDLR)
               && ge(age[A_SRX], XSR_CYCLES);
         end
         `CMD_WR, `CMD_WRA: begin
            legal = legal && open_ff[cmd_bank] && !wbusy_ff
               && ge(age[cmd_bank], T_RCDW);
         end
         `CMD_PRE: begin
            legal = legal && open_ff[cmd_bank] && ge(age[cmd_bank], T_RAS)
               && ge(age[A_WR + cmd_bank], T_WR);
         end
         `CMD_REF, `CMD_MRS: begin
            legal = legal && all_closed;
         end
         `CMD_SRE: begin
            legal = legal && all_closed && ge(age[A_CKE], `CKE_MIN);
         end
         `CMD_SRX: begin
            legal = sr_ff && ge(age[A_CKE], `CKE_MIN);
         end
         default: begin
            legal = 1'b0;
         end
      endcase
   end

   // ready only at a launch tick, so a command is held until then
   assign cmd_ready = tick & legal;
   assign take = cmd_valid & cmd_ready;

   // events restart the age counters and pick the pin code
   always @* begin
      ev = {NAGE{1'b0}};
      nxt_pin = `PIN_NOP;
      if (take) begin
         case (cmd_code)
            `CMD_ACT: begin
               ev[A_ACT] = 1'b1;
               ev[A_FAW + faw_ptr_ff] = 1'b1;
               ev[cmd_bank] = 1'b1;
               nxt_pin = `PIN_ACT;
            end
            `CMD_RD: nxt_pin = `PIN_RD;
            `CMD_WR, `CMD_WRA: begin
               ev[A_WRG] = 1'b1;
               ev[A_WR + cmd_bank] = 1'b1;
               nxt_pin = `PIN_WR;
            end
            `CMD_PRE: begin
               ev[A_PRE + cmd_bank] = 1'b1;
               nxt_pin = `PIN_PRE;
            end
            `CMD_REF: begin
               ev[A_REF] = 1'b1;
               nxt_pin = `PIN_REF;
            end
            `CMD_MRS: begin
               ev[A_MRS] = 1'b1;
               nxt_pin = `PIN_MRS;
            end
            `CMD_SRE: begin
               ev[A_CKE] = 1'b1;
               ev[A_REF] = 1'b1;
               nxt_pin = `PIN_REF;
            end
            `CMD_SRX: begin
               ev[A_CKE] = 1'b1;
               ev[A_SRX] = 1'b1;
            end
            default: nxt_pin = `PIN_NOP;
         endcase
      end
   end

   // pins, bank state and self refresh state move only at launch ticks
   always @(posedge mclk) begin
      if (srst) begin
         pin_ff <= `PIN_NOP;
         ba_ff <= 3'h0;
         addr_ff <= 13'h0000;
         cke_ff <= 1'b1;
         sr_ff <= 1'b0;
         open_ff <= 8'h00;
         apre_ff <= 8'h00;
         faw_ptr_ff <= 2'h0;
      end else if (tick) begin
         pin_ff <= nxt_pin;
         if (take) begin
            ba_ff <= cmd_bank;
            addr_ff <= cmd_addr;
            if (cmd_code == `CMD_WRA) begin
               addr_ff[`AP_BIT] <= 1'b1;
            end else if (cmd_code == `CMD_WR) begin
               addr_ff[`AP_BIT] <= 1'b0;
            end
         end
         if (take && cmd_code == `CMD_ACT) begin
            open_ff <= open_ff | bsel;
            apre_ff <= apre_ff & ~bsel;
            faw_ptr_ff <= faw_ptr_ff + 2'h1;
         end
         if (take && cmd_code == `CMD_PRE) begin
            open_ff <= open_ff & ~bsel;
         end
         if (take && cmd_code == `CMD_WRA) begin
            open_ff <= open_ff & ~bsel;
            apre_ff <= apre_ff | bsel; // bank closes itself after the burst
         end
         if (take && cmd_code == `CMD_SRE) begin
            cke_ff <= 1'b0;
            sr_ff <= 1'b1;
         end
         if (take && cmd_code == `CMD_SRX) begin
            cke_ff <= 1'b1;
            sr_ff <= 1'b0;
         end
      end
   end

   // strobe shape per half clock: predrive high, preamble low, toggle,
   // postamble low, final high driven by us, then release
   always @* begin
      nxt_ws = 1'b1;
      nxt_ws_oe_n = 1'b1;
      if (wbusy_ff) begin
         if (hs_ff >= H_PRE_HI && hs_ff < H_PRE_LO) begin
            nxt_ws_oe_n = 1'b0; // already high, so no rise here
         end else if (hs_ff >= H_PRE_LO && hs_ff < H_BURST) begin
            nxt_ws = 1'b0;
            nxt_ws_oe_n = 1'b0;
         end else if (hs_ff >= H_BURST && hs_ff < H_POST) begin
            nxt_ws = ~hs_ff[0];
            nxt_ws_oe_n = 1'b0;
         end else if (hs_ff == H_POST) begin
            nxt_ws = 1'b0;
            nxt_ws_oe_n = 1'b0;
         end else if (hs_ff == H_POST + 8'h01) begin
            nxt_ws = 1'b1;
            nxt_ws_oe_n = 1'b0; // termination alone may not lift it
         end
      end
   end

   always @(posedge mclk) begin
      if (srst) begin
         wbusy_ff <= 1'b0;
         hs_ff <= 8'h00;
         ws_ff <= 1'b1;
         ws_oe_n_ff <= 1'b1;
      end else begin
         if (take && (cmd_code == `CMD_WR || cmd_code == `CMD_WRA)) begin
            wbusy_ff <= 1'b1;
            hs_ff <= 8'h00;
         end else if (wbusy_ff && half) begin
            hs_ff <= hs_ff + 8'h01;
            wbusy_ff <= (hs_ff + 8'h01 < H_END);
         end
         if (half) begin
            ws_ff <= nxt_ws;
            ws_oe_n_ff <= nxt_ws_oe_n;
         end
      end
   end

   assign self_refresh = sr_ff;
   assign ck_out = ck_ff;
   assign cke_out = cke_ff;
   assign cs_n_out = pin_ff[3];
   assign ras_n_out = pin_ff[2];
   assign cas_n_out = pin_ff[1];
   assign we_n_out = pin_ff[0];
   assign ba_out = ba_ff;
   assign addr_out = addr_ff;
   assign write_strobe_out = ws_ff;
   assign write_strobe_oe_n = ws_oe_n_ff;
endmodule // sgram_command_timing_guard
`default_nettype wire

// ==== sgram_timing_map.vh ====
// Purpose: constants for the graphics DRAM command timing guard
// Assumes: counts are in command clock cycles unless named _NS
// Notes: grade index 0..3 runs from slowest to fastest part
`ifndef SGRAM_TIMING_MAP_VH
`define SGRAM_TIMING_MAP_VH

// user command codes
`define CMD_NOP 4'h0
`define CMD_ACT 4'h1
`define CMD_RD 4'h2
`define CMD_WR 4'h3
`define CMD_WRA 4'h4
`define CMD_PRE 4'h5
`define CMD_REF 4'h6
`define CMD_MRS 4'h7
`define CMD_SRE 4'h8
`define CMD_SRX 4'h9

// pin codes {cs_n, ras_n, cas_n, we_n}
`define PIN_NOP 4'h7
`define PIN_ACT 4'h3
`define PIN_RD 4'h5
`define PIN_WR 4'h4
`define PIN_PRE 4'h2
`define PIN_REF 4'h1
`define PIN_MRS 4'h0
`define AP_BIT 10

// timing by grade: G0, G2 and G3 values, only two for CDLR and XSNR
`define RFC_G0 71
`define RFC_G2 62
`define RFC_G3 57
`define RCDR_G0 18
`define RCDR_G2 16
`define RCDR_G3 15
`define RCDW_G0 14
`define RCDW_G2 12
`define RCDW_G3 11
`define RRD_G0 14
`define RRD_G2 12
`define RRD_G3 11
`define WR_G0 17
`define WR_G2 15
`define WR_G3 14
`define CDLR_G0 9
`define CDLR_G2 8
`define MRD_G0 11
`define MRD_G2 10
`define MRD_G3 9
`define DAL_G0 34
`define DAL_G2 30
`define DAL_G3 28
`define XSNR_G0 120
`define XSNR_G3 110
`define FAW_G0 70
`define FAW_G2 60
`define FAW_G3 55
`define RAS_G0 40
`define RAS_G2 35
`define RAS_G3 32
`define RC_G0 57
`define RC_G2 50
`define RC_G3 46
`define RP_G0 17
`define RP_G2 15
`define RP_G3 14
`define XSR_CK 20000
`define RAS_MAX_CK 100000
`define CKE_MIN 5
`define REFRESH_INTERVAL_NS 3900
`define MCLK_NS 10
`define AGE_W 17

`endif

// ==== event_age_counter.v ====
// Purpose: counts command clock cycles since an event, saturating
// Assumes: tick is a one-cycle pulse once per command clock
// Notes: reset leaves the counter saturated so every minimum spacing is met
`timescale 1ns/100ps
`default_nettype none
module event_age_counter #(
   parameter W = 17
) (
   input wire mclk,
   input wire srst,
   input wire tick,
   input wire clear,
   output wire [W-1:0] age
);
   reg [W-1:0] age_ff;
   reg [W-1:0] nxt_age;

   // event restarts at one so age equals ticks elapsed at later ticks
   always @* begin
      nxt_age = age_ff;
      if (tick && clear) begin
         nxt_age = {{(W-1){1'b0}}, 1'b1};
      end else if (tick && (age_ff != {W{1'b1}})) begin
         nxt_age = age_ff + {{(W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge mclk) begin
      if (srst) begin
         age_ff <= {W{1'b1}};
      end else begin
         age_ff <= nxt_age;
      end
   end

   assign age = age_ff;
endmodule // event_age_counter
`default_nettype wire

// ==== sgram_guard_properties.sv ====
// Purpose: pin side timing checks for the command timing guard
// Assumes: GRADE and CK_HALF match the bound instance
// Notes: ages count command clock falls, the strobe drive age mclk cycles, saturating at 255
`timescale 1ns/100ps
`default_nettype none
`include "sgram_timing_map.vh"
module sgram_guard_properties #(
   parameter GRADE = 0,
   parameter CK_HALF = 8
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic ck_out,
   input wire logic cke_out,
   input wire logic cs_n_out,
   input wire logic ras_n_out,
   input wire logic cas_n_out,
   input wire logic we_n_out,
   input wire logic write_strobe_out,
   input wire logic write_strobe_oe_n
);
   localparam int RFC = GRADE > 2 ? `RFC_G3 : GRADE == 2 ? `RFC_G2 : `RFC_G0;
   localparam int RRD = GRADE > 2 ? `RRD_G3 : GRADE == 2 ? `RRD_G2 : `RRD_G0;
   localparam int MRD = GRADE > 2 ? `MRD_G3 : GRADE == 2 ? `MRD_G2 : `MRD_G0;
   localparam int FAW = GRADE > 2 ? `FAW_G3 : GRADE == 2 ? `FAW_G2 : `FAW_G0;
   localparam int XSNR = GRADE > 2 ? `XSNR_G3 : `XSNR_G0;
   logic ck_ff, cke_ff, fall, go;
   logic [3:0] pins;
   logic [7:0] ref_age_ff, mrs_age_ff, srx_age_ff, cke_age_ff, drv_age_ff;
   logic [7:0] act_age_ff [0:3];
   // a launch is seen one cycle after the command clock falls
   assign pins = {cs_n_out, ras_n_out, cas_n_out, we_n_out};
   assign fall = ck_ff & ~ck_out;
   assign go = fall & (pins != `PIN_NOP);
   function automatic logic [7:0] inc(input logic [7:0] v);
      return (v == 8'hff) ? v : v + 8'h01;
   endfunction
   // saturating ages, so a long idle spell never wraps into a false hit
   always_ff @(posedge mclk) begin
      ck_ff <= ck_out;
      cke_ff <= cke_out;
      drv_age_ff <= (srst || write_strobe_oe_n) ? 8'h00 : inc(drv_age_ff);
      if (srst) begin
         ref_age_ff <= 8'hff;
         mrs_age_ff <= 8'hff;
         srx_age_ff <= 8'hff;
         cke_age_ff <= 8'hff;
         for (int i = 0; i < 4; i++) act_age_ff[i] <= 8'hff;
      end else if (fall) begin
         ref_age_ff <= (go && pins == `PIN_REF) ? 8'h00 : inc(ref_age_ff);
         mrs_age_ff <= (go && pins == `PIN_MRS) ? 8'h00 : inc(mrs_age_ff);
         srx_age_ff <= (cke_out && !cke_ff) ? 8'h00 : inc(srx_age_ff);
         cke_age_ff <= (cke_out != cke_ff) ? 8'h00 : inc(cke_age_ff);
         act_age_ff[0] <= (go && pins == `PIN_ACT) ? 8'h00 : inc(act_age_ff[0]);
         for (int i = 1; i < 4; i++)
            act_age_ff[i] <= (go && pins == `PIN_ACT) ? inc(act_age_ff[i-1]) : inc(act_age_ff[i]);
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   sequence s_launch;
      go;
   endsequence
   sequence s_act;
      go && pins == `PIN_ACT;
   endsequence
   a_refresh_busy: assert property (s_launch |-> ref_age_ff >= RFC - 1)
      else $error("command inside refresh busy time");
   a_act_spacing: assert property (s_act |-> act_age_ff[0] >= RRD - 1)
      else $error("activates too close");
   a_four_window: assert property (s_act |-> act_age_ff[3] >= FAW - 1)
      else $error("fifth activate inside window");
   a_mode_wait: assert property (s_launch |-> mrs_age_ff >= MRD - 1)
      else $error("command too soon after mode set");
   a_exit_wait: assert property (go && pins != `PIN_RD |-> srx_age_ff >= XSNR - 1)
      else $error("command too soon after self refresh exit");
   a_cke_hold: assert property (fall && cke_out != cke_ff |-> cke_age_ff >= `CKE_MIN - 1)
      else $error("clock enable pulse too short");
   a_strobe_pre: assert property (!write_strobe_oe_n && drv_age_ff < 2 * CK_HALF |-> write_strobe_out)
      else $error("strobe not high before preamble");
   a_strobe_post: assert property ($rose(write_strobe_oe_n) |-> $past(write_strobe_out) && !$past(write_strobe_out, CK_HALF + 1))
      else $error("strobe released without driven high edge");
endmodule // sgram_guard_properties
bind sgram_command_timing_guard sgram_guard_properties #(
   .GRADE(GRADE),
   .CK_HALF(CK_HALF)
) u_sgram_guard_properties (
   .mclk(mclk), .srst(srst), .ck_out(ck_out), .cke_out(cke_out),
   .cs_n_out(cs_n_out), .ras_n_out(ras_n_out), .cas_n_out(cas_n_out), .we_n_out(we_n_out),
   .write_strobe_out(write_strobe_out), .write_strobe_oe_n(write_strobe_oe_n)
);
`default_nettype wire

// ==== sgram_device_model.sv ====
// Purpose: behavioural graphics DRAM seen from its command pins
// Assumes: commands sampled on the rising command clock
// Notes: counts protocol faults and driven strobe rises
`timescale 1ns/100ps
`default_nettype none
`include "sgram_timing_map.vh"
module sgram_device_model (
   input wire logic ck,
   input wire logic cke,
   input wire logic [3:0] pins,
   input wire logic [2:0] ba,
   input wire logic ap,
   input wire logic strobe,
   input wire logic strobe_oe_n,
   output logic [7:0] open_banks,
   output logic self_ref,
   output logic [15:0] fault_count,
   output logic [15:0] strobe_rises
);
   // termination pulls the released strobe high; no data outputs are driven here
   wire line = strobe_oe_n ? 1'b1 : strobe;
   initial begin
      open_banks = 8'h00;
      self_ref = 1'b0;
      fault_count = 16'h0000;
      strobe_rises = 16'h0000;
   end
   // only rises driven by the controller count
   always @(posedge line) begin
      if (!strobe_oe_n) strobe_rises <= strobe_rises + 16'h0001;
   end
   // bank state and illegal command detection
   always @(posedge ck) begin
      logic bad;
      bad = self_ref && !cke && pins != `PIN_NOP;
      self_ref <= cke ? 1'b0 : (pins == `PIN_REF || self_ref);
      case (pins)
         `PIN_ACT: begin
            bad = bad || open_banks[ba];
            open_banks[ba] <= 1'b1;
         end
         `PIN_RD: bad = bad || !open_banks[ba];
         `PIN_WR: begin
            bad = bad || !open_banks[ba];
            if (ap) open_banks[ba] <= 1'b0;
         end
         `PIN_PRE: begin
            bad = bad || !open_banks[ba];
            open_banks[ba] <= 1'b0;
         end
         `PIN_REF, `PIN_MRS: bad = bad || open_banks != 8'h00;
         default: bad = bad;
      endcase
      if (bad) fault_count <= fault_count + 16'h0001;
   end
endmodule // sgram_device_model
`default_nettype wire

// ==== sgram_command_timing_guard_tb.sv ====
// Purpose: directed bench for the command timing guard
// Assumes: grade 0, command clock of two mclk cycles
// Notes: command times are reckoned in command clocks from a base refresh
`timescale 1ns/100ps
`default_nettype none
`include "sgram_timing_map.vh"
module sgram_command_timing_guard_tb;
   localparam int CKH = 1;
   localparam int TK = 2 * CKH;
   localparam int XSR = 150;
   localparam int RASMAX = 300;
   localparam int WDAT = 4 + 8 / 2;
   localparam int REFI = `REFRESH_INTERVAL_NS / (TK * `MCLK_NS);
   logic mclk, srst, cmd_valid;
   logic [3:0] cmd_code;
   logic [2:0] cmd_bank;
   logic [12:0] cmd_addr;
   wire cmd_ready, refresh_due, row_overdue, self_refresh, ck_out, cke_out;
   wire cs_n_out, ras_n_out, cas_n_out, we_n_out, write_strobe_out, write_strobe_oe_n;
   wire [2:0] ba_out;
   wire [12:0] addr_out;
   wire [7:0] open_banks;
   wire self_ref;
   wire [15:0] fault_count, strobe_rises;
   int mismatches, num_checks;
   time t_last, t_base;
   sgram_command_timing_guard #(.GRADE(0), .CK_HALF(CKH), .WL(4), .BL(8), .XSR_CYCLES(XSR),
      .RAS_MAX_CYCLES(RASMAX)) u_sgram_command_timing_guard (
      .mclk(mclk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
      .refresh_due(refresh_due), .row_overdue(row_overdue), .self_refresh(self_refresh),
      .ck_out(ck_out), .cke_out(cke_out), .cs_n_out(cs_n_out), .ras_n_out(ras_n_out),
      .cas_n_out(cas_n_out), .we_n_out(we_n_out), .ba_out(ba_out), .addr_out(addr_out),
      .write_strobe_out(write_strobe_out), .write_strobe_oe_n(write_strobe_oe_n));
   sgram_device_model u_sgram_device_model (
      .ck(ck_out), .cke(cke_out), .pins({cs_n_out, ras_n_out, cas_n_out, we_n_out}),
      .ba(ba_out), .ap(addr_out[`AP_BIT]), .strobe(write_strobe_out),
      .strobe_oe_n(write_strobe_oe_n), .open_banks(open_banks), .self_ref(self_ref),
      .fault_count(fault_count), .strobe_rises(strobe_rises));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   function automatic int now();
      return int'((t_last - t_base) / (TK * `MCLK_NS));
   endfunction
   // holds the offer until taken; exp below zero means the moment is not judged
   task automatic issue(input logic [3:0] c, input logic [2:0] b, input int exp);
      int n;
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_bank <= b;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 4000);
      @(posedge mclk);
      cmd_valid <= 1'b0;
      t_last = $time;
      if (n >= 4000) check("command taken", 1, 0);
      if (exp >= 0) check("command clock of acceptance", exp, now());
   endtask
   task automatic t_rows();
      issue(`CMD_REF, 3'h0, -1);
      t_base = t_last;
      repeat (3) @(negedge mclk);
      check("refresh_due cleared", 0, refresh_due);
      issue(`CMD_ACT, 3'h0, `RFC_G0);
      issue(`CMD_ACT, 3'h1, `RFC_G0 + `RRD_G0);
      issue(`CMD_RD, 3'h0, `RFC_G0 + `RCDR_G0);
      issue(`CMD_WR, 3'h1, `RFC_G0 + `RRD_G0 + `RCDW_G0);
      issue(`CMD_RD, 3'h1, now() + WDAT + `CDLR_G0);
      check("driven strobe rises", 8 / 2 + 1, strobe_rises);
   endtask
   task automatic t_close();
      issue(`CMD_PRE, 3'h1, `RFC_G0 + `RRD_G0 + `RAS_G0);
      issue(`CMD_PRE, 3'h0, -1);
      issue(`CMD_ACT, 3'h0, now() + `RP_G0);
      issue(`CMD_PRE, 3'h0, now() + `RAS_G0);
      repeat (6) @(negedge mclk);
      check("open banks", 0, open_banks);
   endtask
   task automatic t_window();
      issue(`CMD_REF, 3'h0, -1);
      t_base = t_last;
      issue(`CMD_MRS, 3'h0, `RFC_G0);
      issue(`CMD_ACT, 3'h1, `RFC_G0 + `MRD_G0);
      for (int i = 2; i <= 4; i++) issue(`CMD_ACT, i[2:0], `RFC_G0 + `MRD_G0 + (i - 1) * `RRD_G0);
      issue(`CMD_ACT, 3'h5, `RFC_G0 + `MRD_G0 + `FAW_G0);
      for (int i = 1; i <= 4; i++) issue(`CMD_PRE, i[2:0], -1);
      issue(`CMD_PRE, 3'h5, `RFC_G0 + `MRD_G0 + `FAW_G0 + `RAS_G0);
      repeat (6) @(negedge mclk);
      check("open banks", 0, open_banks);
   endtask
   // autoclose write then reopen; a later plain write sets the precharge time
   task automatic t_autoclose();
      issue(`CMD_REF, 3'h0, -1);
      t_base = t_last;
      issue(`CMD_ACT, 3'h0, `RFC_G0);
      issue(`CMD_RD, 3'h0, `RFC_G0 + `RCDR_G0);
      issue(`CMD_WRA, 3'h0, -1);
      issue(`CMD_ACT, 3'h0, now() + WDAT + `DAL_G0);
      issue(`CMD_RD, 3'h0, now() + `RCDR_G0);
      issue(`CMD_WR, 3'h0, -1);
      issue(`CMD_PRE, 3'h0, now() + WDAT + `WR_G0);
      check("driven strobe rises", 3 * (8 / 2 + 1), strobe_rises);
   endtask
   task automatic t_self_refresh();
      issue(`CMD_REF, 3'h0, -1);
      t_base = t_last;
      issue(`CMD_SRE, 3'h0, `RFC_G0);
      repeat (6) @(negedge mclk);
      check("clock enable in self refresh", 0, cke_out);
      check("self refresh flag", 1, {self_refresh, self_ref} == 2'b11);
      issue(`CMD_SRX, 3'h0, `RFC_G0 + `CKE_MIN);
      issue(`CMD_ACT, 3'h0, `RFC_G0 + `CKE_MIN + `XSNR_G0);
      issue(`CMD_RD, 3'h0, `RFC_G0 + `CKE_MIN + XSR);
      repeat ((`RFC_G0 + REFI - 2 - now()) * TK) @(negedge mclk);
      check("refresh_due early", 0, refresh_due);
      repeat (3 * TK) @(negedge mclk);
      check("refresh_due on time", 1, refresh_due);
      // bank 0 stays open from the activate after exit until the limit runs out
      repeat ((`CKE_MIN + `XSNR_G0 + RASMAX - REFI - 3) * TK) @(negedge mclk);
      check("row_overdue early", 0, row_overdue);
      repeat (3 * TK) @(negedge mclk);
      check("row_overdue on time", 1, row_overdue);
   endtask
   // bounded run in case the guard stalls a command forever
   initial begin
      #200000;
      mismatches++;
      test_done();
   end
   initial begin
      srst = 1'b1;
      cmd_valid = 1'b0;
      cmd_code = `CMD_NOP;
      cmd_bank = 3'h0;
      cmd_addr = 13'h0040;
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      t_rows();
      t_close();
      t_window();
      t_autoclose();
      t_self_refresh();
      check("device protocol faults", 0, fault_count);
      test_done();
   end
endmodule // sgram_command_timing_guard_tb
`default_nettype wire
